// ### inc/adc_ctrl_params.svh
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

// Word layout
`define WORD_W 16
`define SEL_BIT 15
`define CFG_REF_BIT 10
`define CFG_AVG_BIT 9
// Select codes
`define CFG_CODE 5'h10
`define SEQ_CODE 5'h16
// Scan codes
`define SCAN_USER 4'h9
`define SCAN_RSV_LO 4'ha
// Power field codes
`define PWR_FULL 2'h1
`define PWR_BIAS 2'h2
// Reset values
`define SCAN_RST 4'h0
`define PICK_RST 4'h0
`define AUTO_PD_RST 2'h0
`define STATIC_PD_RST 2'h0
`define REF_SEL_RST 1'h0
`define AVG_ON_RST 1'h0
// Frames discarded after a wake on select
`define WAKE_FRAMES 2'h2
// User sequence depth
`define SEQ_DEPTH 256
`endif

// ### inc/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // Mode control word, select bit low
  typedef struct packed {
    logic sel;
    logic [3:0] scan;
    logic [3:0] pick;
    logic rsv6;
    logic [1:0] auto_pd;
    logic [1:0] rsv3;
    logic sw_convert;
    logic rsv0;
  } mode_word_t;

  // Configuration word
  typedef struct packed {
    logic [4:0] code;
    logic ref_sel;
    logic avg_on;
    logic [4:0] rsv8;
    logic [1:0] static_pd;
    logic [1:0] rsv1;
  } config_word_t;

  // Power rails seen by the analog core
  typedef struct packed {
    logic full_off;
    logic bias_only;
    logic results_valid;
  } power_out_t;

  typedef enum logic [1:0] {
    PWR_AWAKE = 2'b01,
    PWR_ASLEEP = 2'b10
  } power_state_t;

endpackage

// ### rtl/link_receiver.sv
`timescale 1ns/1ps
`include "adc_ctrl_params.svh"
module link_receiver (
  input wire logic i_sclk, // Serial clock from host
  input wire logic i_cs_n, // Frame select, low in frame
  input wire logic i_din, // Serial data, MSB first
  output logic [15:0] o_word, // Last full word received
  output logic o_ready // High once 16 bits are in
);

  logic [4:0] bit_count;
  logic [15:0] shift;

  // Bit counter and ready, cleared by the frame end
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      bit_count <= 5'h00;
      o_ready <= 1'b0;
    end else if (bit_count < 5'(`WORD_W)) begin
      bit_count <= bit_count + 5'h01;
      o_ready <= (bit_count == 5'(`WORD_W - 1));
    end
  end

  // Shift register; extra bits past 16 ignored
  always_ff @(posedge i_sclk) begin
    if (!i_cs_n && bit_count < 5'(`WORD_W)) begin
      shift <= {shift[14:0], i_din};
    end
  end

  // Word held until the next frame completes
  always_ff @(posedge i_sclk) begin
    if (!i_cs_n && bit_count == 5'(`WORD_W - 1)) begin
      o_word <= {shift[14:0], i_din};
    end
  end

endmodule

// ### rtl/adc_scan_power_control.sv
`timescale 1ns/1ps
`include "adc_ctrl_params.svh"
module adc_scan_power_control
  import adc_ctrl_pkg::*;
(
  input wire logic i_clock, // System clock, 25 MHz
  input wire logic i_rst_n, // Synchronous reset, active low
  input wire logic i_sclk, // Serial link clock
  input wire logic i_cs_n, // Frame select pin
  input wire logic i_din, // Serial data pin
  input wire logic i_convert_strobe_n, // Convert strobe pin
  input wire logic i_conversions_done, // Core finished request
  output logic [3:0] o_scan_mode, // Active scan code
  output logic [3:0] o_channel, // Channel of this frame
  output logic o_internal_clock, // Internal clock mode active
  output logic o_reference_select, // 1 differential reference
  output logic o_averaging_active, // Averaging in effect
  output logic o_full_off, // All circuitry off
  output logic o_bias_only, // Only bias generator on
  output logic o_results_valid // Conversions may be used
);

  logic [15:0] link_word;
  logic link_ready;
  logic [2:0] cs_sync;
  logic [2:0] rdy_sync;
  logic [2:0] cnv_sync;
  logic cs_fall;
  logic cs_rise;
  logic word_take;
  logic strobe_fall;
  mode_word_t mw;
  config_word_t cw;
  logic is_mode;
  logic mode_ok;
  logic is_cfg;
  logic is_seqhdr;
  logic is_load;
  logic [3:0] scan_mode;
  logic [3:0] channel_pick;
  logic [1:0] auto_powerdown_sel;
  logic software_convert;
  logic reference_select;
  logic averaging_on;
  logic [1:0] static_powerdown_sel;
  logic [3:0] seq_mem [`SEQ_DEPTH];
  logic [7:0] seq_len;
  logic [7:0] wr_ptr;
  logic [6:0] load_left;
  logic [7:0] seq_idx;
  power_state_t pwr_state;
  logic [1:0] sleep_kind;
  logic [1:0] auto_pd_frame;
  logic [1:0] warm;
  logic internal;
  power_out_t pwr_out;
  power_out_t next_pwr_out;

  // Serial word capture on the link clock
  link_receiver u_link (
    .i_sclk(i_sclk),
    .i_cs_n(i_cs_n),
    .i_din(i_din),
    .o_word(link_word),
    .o_ready(link_ready)
  );

  // Two-stage synchronisers plus an edge stage
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cs_sync <= 3'h7;
      rdy_sync <= 3'h0;
      cnv_sync <= 3'h7;
    end else begin
      cs_sync <= {cs_sync[1:0], i_cs_n};
      rdy_sync <= {rdy_sync[1:0], link_ready};
      cnv_sync <= {cnv_sync[1:0], i_convert_strobe_n};
    end
  end

  // Edge events, taken after the second stage
  assign cs_fall = cs_sync[2] & ~cs_sync[1];
  assign cs_rise = ~cs_sync[2] & cs_sync[1];
  assign word_take = rdy_sync[1] & ~rdy_sync[2];
  assign strobe_fall = cnv_sync[2] & ~cnv_sync[1];

  // Word decode; held word is stable when taken
  assign mw = mode_word_t'(link_word);
  assign cw = config_word_t'(link_word);
  assign is_load = word_take && (load_left != 7'h00);
  assign is_mode = word_take && (load_left == 7'h00) && !mw.sel;
  assign mode_ok = is_mode && (mw.scan < `SCAN_RSV_LO);
  assign is_cfg = word_take && (load_left == 7'h00)
    && (cw.code == `CFG_CODE);
  assign is_seqhdr = word_take && (load_left == 7'h00)
    && (cw.code == `SEQ_CODE);

  // Internal clock modes; user sequence is external only
  always_comb begin
    unique case (scan_mode)
      4'h2, 4'h3, 4'h5, 4'h7: internal = 1'b1;
      default: internal = 1'b0;
    endcase
  end

  // Mode control fields; reserved codes leave all alone
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      scan_mode <= `SCAN_RST;
      channel_pick <= `PICK_RST;
      auto_powerdown_sel <= `AUTO_PD_RST;
    end else if (mode_ok) begin
      scan_mode <= mw.scan;
      channel_pick <= mw.pick;
      auto_powerdown_sel <= mw.auto_pd;
    end
  end

  // Software convert request, consumed at frame end
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      software_convert <= 1'b0;
    end else if (mode_ok && mw.sw_convert) begin
      software_convert <= 1'b1;
    end else if (cs_rise) begin
      software_convert <= 1'b0;
    end
  end

  // Configuration fields; other words leave them unchanged
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      reference_select <= `REF_SEL_RST;
      averaging_on <= `AVG_ON_RST;
      static_powerdown_sel <= `STATIC_PD_RST;
    end else if (is_cfg) begin
      reference_select <= cw.ref_sel;
      averaging_on <= cw.avg_on;
      static_powerdown_sel <= cw.static_pd;
    end
  end

  // Sequence header sets length, then list words follow
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      seq_len <= 8'h00;
      wr_ptr <= 8'h00;
      load_left <= 7'h00;
    end else if (is_seqhdr) begin
      seq_len <= link_word[7:0];
      wr_ptr <= 8'h00;
      load_left <= {1'b0, link_word[7:2]} + 7'h01;
    end else if (is_load) begin
      wr_ptr <= wr_ptr + 8'h04;
      load_left <= load_left - 7'h01;
    end
  end

  // Four channel entries per list word, first in top nibble
  always_ff @(posedge i_clock) begin
    if (is_load) begin
      for (int i = 0; i < 4; i++) begin
        seq_mem[8'(wr_ptr + 8'(i))] <= link_word[15 - 4 * i -: 4];
      end
    end
  end

  // Channel for each frame: list entry or channel pick
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_channel <= `PICK_RST;
      seq_idx <= 8'h00;
    end else if (cs_fall) begin
      if (scan_mode == `SCAN_USER) begin
        o_channel <= seq_mem[seq_idx];
        seq_idx <= (seq_idx == seq_len) ? 8'h00 : seq_idx + 8'h01;
      end else begin
        o_channel <= channel_pick;
        seq_idx <= 8'h00;
      end
    end
  end

  // Power field in force at the start of each frame
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      auto_pd_frame <= `AUTO_PD_RST;
    end else if (cs_fall) begin
      auto_pd_frame <= auto_powerdown_sel;
    end
  end

  // Automatic sleep and wake; register fields are untouched
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pwr_state <= PWR_AWAKE;
      sleep_kind <= `AUTO_PD_RST;
      warm <= 2'h0;
    end else begin
      unique case (pwr_state)
        PWR_AWAKE: begin
          if (warm != 2'h0 && cs_rise) begin
            warm <= warm - 2'h1;
          end
          if (!internal && cs_rise && (auto_pd_frame == `PWR_FULL
              || auto_pd_frame == `PWR_BIAS)) begin
            pwr_state <= PWR_ASLEEP;
            sleep_kind <= auto_pd_frame;
          end else if (internal && i_conversions_done
              && (auto_powerdown_sel == `PWR_FULL
              || auto_powerdown_sel == `PWR_BIAS)) begin
            pwr_state <= PWR_ASLEEP;
            sleep_kind <= auto_powerdown_sel;
          end
        end
        PWR_ASLEEP: begin
          if (!internal && cs_fall) begin
            pwr_state <= PWR_AWAKE;
            warm <= `WAKE_FRAMES;
          end else if (internal && (strobe_fall
              || (cs_rise && software_convert))) begin
            pwr_state <= PWR_AWAKE;
          end
        end
      endcase
    end
  end

  // Rail controls: static or automatic selection, full off wins over bias
  always_comb begin
    next_pwr_out.full_off = (static_powerdown_sel == `PWR_FULL)
      || (pwr_state == PWR_ASLEEP && sleep_kind == `PWR_FULL);
    next_pwr_out.bias_only = !next_pwr_out.full_off
      && ((static_powerdown_sel == `PWR_BIAS)
      || (pwr_state == PWR_ASLEEP && sleep_kind == `PWR_BIAS));
    next_pwr_out.results_valid = (pwr_state == PWR_AWAKE)
      && (warm == 2'h0) && !next_pwr_out.full_off
      && !next_pwr_out.bias_only;
  end

  // Registered rail outputs
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pwr_out <= '0;
    end else begin
      pwr_out <= next_pwr_out;
    end
  end

  // Output map
  assign o_full_off = pwr_out.full_off;
  assign o_bias_only = pwr_out.bias_only;
  assign o_results_valid = pwr_out.results_valid;
  assign o_scan_mode = scan_mode;
  assign o_internal_clock = internal;
  assign o_reference_select = reference_select;
  assign o_averaging_active = averaging_on && internal;

  // Checks on the system clock
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  property p_reserved_ignored;
    is_mode && mw.scan >= `SCAN_RSV_LO |=>
      scan_mode == $past(scan_mode)
      && channel_pick == $past(channel_pick)
      && auto_powerdown_sel == $past(auto_powerdown_sel);
  endproperty
  a_reserved_ignored: assert property (p_reserved_ignored)
    else $error("reserved scan code changed mode");

  property p_cfg_write;
    is_cfg |=> reference_select == $past(link_word[`CFG_REF_BIT])
      && averaging_on == $past(link_word[`CFG_AVG_BIT]);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("config word not stored");

  property p_cfg_hold;
    !is_cfg |=> $stable(reference_select) && $stable(averaging_on)
      && $stable(static_powerdown_sel);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("config changed without config word");

  property p_avg_internal;
    o_averaging_active |-> internal && scan_mode != `SCAN_USER;
  endproperty
  a_avg_internal: assert property (p_avg_internal)
    else $error("averaging outside internal clock mode");

  property p_static_full;
    static_powerdown_sel == `PWR_FULL |=> o_full_off && !o_results_valid;
  endproperty
  a_static_full: assert property (p_static_full)
    else $error("static full shutdown not applied");

  property p_ext_sleep;
    pwr_state == PWR_AWAKE && !internal && cs_rise
      && auto_pd_frame == `PWR_BIAS ##1 1'b1 |=> o_bias_only;
  endproperty
  a_ext_sleep: assert property (p_ext_sleep)
    else $error("no standby after frame end");

  property p_ext_wake;
    pwr_state == PWR_ASLEEP && !internal && cs_fall |=>
      pwr_state == PWR_AWAKE ##1 !o_results_valid;
  endproperty
  a_ext_wake: assert property (p_ext_wake)
    else $error("wake on select missing or valid too soon");

  property p_int_sleep;
    pwr_state == PWR_AWAKE && internal && i_conversions_done
      && auto_powerdown_sel == `PWR_FULL |=> pwr_state == PWR_ASLEEP
      ##1 o_full_off;
  endproperty
  a_int_sleep: assert property (p_int_sleep)
    else $error("no shutdown after conversions");

  property p_strobe_wake;
    pwr_state == PWR_ASLEEP && internal && strobe_fall
      |=> pwr_state == PWR_AWAKE;
  endproperty
  a_strobe_wake: assert property (p_strobe_wake)
    else $error("no wake on convert strobe");

  property p_channel_pick;
    cs_fall && scan_mode != `SCAN_USER |=> o_channel == $past(channel_pick);
  endproperty
  a_channel_pick: assert property (p_channel_pick)
    else $error("frame channel differs from pick");

  property p_keep_regs;
    pwr_state == PWR_ASLEEP && !word_take |=> $stable(scan_mode)
      && $stable(channel_pick) && $stable(reference_select);
  endproperty
  a_keep_regs: assert property (p_keep_regs)
    else $error("registers lost during sleep");

endmodule

// ### tb/host_link_model.sv
`timescale 1ns/1ps
module host_link_model #(
  parameter int HALF_NS = 80 // Half period of the link clock
) (
  output logic o_sclk, // Link clock, still between frames
  output logic o_cs_n, // Frame select
  output logic o_din // Serial data
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din = 1'b1;
  end
  // Open a frame, phase offset from the system clock
  task automatic frame_open();
    #(HALF_NS + 13);
    o_cs_n = 1'b0;
    #(HALF_NS);
  endtask
  // Shift one word MSB first, data set while the clock is low
  task automatic frame_bits(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      o_din = w[i];
      #(HALF_NS);
      o_sclk = 1'b1;
      #(HALF_NS);
      o_sclk = 1'b0;
    end
  endtask
  // Close half a period after the last edge, then idle gap
  task automatic frame_close();
    #(HALF_NS);
    o_cs_n = 1'b1;
    o_din = ~o_din; // Released line shows a changed level
    #(3 * HALF_NS);
  endtask
  // Whole frame, one word
  task automatic send_word(input logic [15:0] w);
    frame_open();
    frame_bits(w);
    frame_close();
  endtask
endmodule

// ### tb/adc_scan_power_control_bench.sv
`timescale 1ns/1ps
`include "adc_ctrl_params.svh"
`define CHECK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module adc_scan_power_control_bench;
  logic i_clock;
  logic i_rst_n;
  logic sclk, cs_n, din;
  logic convert_strobe_n;
  logic conversions_done;
  logic [3:0] scan_mode;
  logic [3:0] channel;
  logic internal_clock, reference_select, averaging_active;
  logic full_off, bias_only, results_valid;
  logic [19:0] seq_list = 20'h72e57;
  int fail_count = 0;
  int n_compared = 0;

  host_link_model host (
    .o_sclk(sclk),
    .o_cs_n(cs_n),
    .o_din(din)
  );

  adc_scan_power_control DUT (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_sclk(sclk),
    .i_cs_n(cs_n),
    .i_din(din),
    .i_convert_strobe_n(convert_strobe_n),
    .i_conversions_done(conversions_done),
    .o_scan_mode(scan_mode),
    .o_channel(channel),
    .o_internal_clock(internal_clock),
    .o_reference_select(reference_select),
    .o_averaging_active(averaging_active),
    .o_full_off(full_off),
    .o_bias_only(bias_only),
    .o_results_valid(results_valid)
  );

  // System clock, 40 ns
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  // Mode word
  function automatic logic [15:0] mw(input logic [3:0] scan,
    input logic [3:0] ch, input logic [1:0] pd, input logic sw);
    return {1'b0, scan, ch, 1'b0, pd, 2'h0, sw, 1'b0};
  endfunction

  // Config word, select code in the top five bits
  function automatic logic [15:0] cw(input logic [4:0] code,
    input logic rs, input logic av, input logic [1:0] sp);
    return {code, rs, av, 5'h00, sp, 2'h0};
  endfunction

  // One frame, then let the effects settle
  task automatic xfer(input logic [15:0] w);
    host.send_word(w);
    repeat (8) @(posedge i_clock);
  endtask

  task automatic pulse_done();
    @(posedge i_clock) conversions_done <= 1'b1;
    @(posedge i_clock) conversions_done <= 1'b0;
    repeat (4) @(posedge i_clock);
  endtask

  task automatic complete_run();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    #2000000;
    fail_count++;
    complete_run();
  end

  initial begin
    i_rst_n = 1'b0;
    convert_strobe_n = 1'b1;
    conversions_done = 1'b0;
    repeat (6) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    // Reset values
    `CHECK(scan_mode, `SCAN_RST)
    `CHECK(channel, `PICK_RST)
    `CHECK(reference_select, `REF_SEL_RST)
    `CHECK(averaging_active, `AVG_ON_RST)
    `CHECK({full_off, bias_only, results_valid}, 3'h1)
    // Config write, then a word under a wrong select code
    xfer(cw(`CFG_CODE, 1'b1, 1'b1, 2'h0));
    `CHECK({reference_select, averaging_active}, 2'h2)
    xfer(cw(5'h11, 1'b0, 1'b0, 2'h1));
    `CHECK({reference_select, full_off}, 2'h2)
    // Every channel picked, channels 0 to 14 checked; a pick shows at the next frame start
    for (int n = 0; n < 16; n++) begin
      xfer(mw(4'h1, 4'(n), 2'h0, 1'b0));
      `CHECK(channel, 4'(n == 0 ? 0 : n - 1))
    end
    xfer(mw(4'h5, 4'h6, 2'h0, 1'b0));
    `CHECK({internal_clock, averaging_active}, 2'h3)
    // Reserved scan codes leave everything as it was
    for (int r = 10; r < 16; r++) begin
      xfer(mw(4'(r), 4'h2, 2'h1, 1'b1));
      `CHECK({scan_mode, channel, full_off}, 9'h0ac)
    end
    `CHECK(reference_select, 1'b1)
    // Static power-down codes
    for (int s = 0; s < 4; s++) begin
      xfer(cw(`CFG_CODE, 1'b1, 1'b0, 2'(s)));
      `CHECK({full_off, bias_only}, 2'(s == 1 ? 2 : s == 2 ? 1 : 0))
    end
    // External mode automatic sleep and wake on select
    for (int p = 1; p < 3; p++) begin
      xfer(mw(4'h1, 4'h4, 2'(p), 1'b0));
      `CHECK({full_off, bias_only}, 2'h0)
      xfer(mw(4'h1, 4'h4, 2'(p), 1'b0));
      `CHECK({full_off, bias_only}, 2'(p == 1 ? 2 : 1))
      `CHECK(reference_select, 1'b1)
      host.frame_open();
      #240; // Six cycles, link edges stay off the clock edges
      `CHECK({full_off, bias_only, results_valid}, 3'h0)
      host.frame_bits(mw(4'h1, 4'h4, 2'h0, 1'b0));
      host.frame_close();
      repeat (8) @(posedge i_clock);
      `CHECK(results_valid, 1'b0)
      xfer(mw(4'h1, 4'h4, 2'h0, 1'b0));
      `CHECK({full_off, bias_only, results_valid}, 3'h0)
      xfer(mw(4'h1, 4'h4, 2'h0, 1'b0));
      `CHECK({full_off, bias_only, results_valid}, 3'h1)
    end
    // Internal mode automatic sleep and both wake sources
    xfer(mw(4'h2, 4'h0, 2'h1, 1'b0));
    pulse_done();
    `CHECK(full_off, 1'b1)
    @(posedge i_clock) convert_strobe_n <= 1'b0;
    repeat (6) @(posedge i_clock);
    convert_strobe_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    `CHECK(full_off, 1'b0)
    pulse_done();
    `CHECK(full_off, 1'b1)
    xfer(mw(4'h2, 4'h0, 2'h1, 1'b0));
    `CHECK({full_off, reference_select}, 2'h3)
    xfer(mw(4'h2, 4'h0, 2'h1, 1'b1));
    `CHECK(full_off, 1'b0)
    xfer(mw(4'h2, 4'h0, 2'h3, 1'b0));
    pulse_done();
    `CHECK({full_off, bias_only}, 2'h0)
    // User sequence of four entries, wraps after the last
    xfer(cw(`CFG_CODE, 1'b1, 1'b1, 2'h0));
    xfer({`SEQ_CODE, 3'h0, 8'h03});
    xfer(16'h72e5);
    xfer(mw(`SCAN_USER, 4'h0, 2'h0, 1'b0));
    `CHECK({internal_clock, averaging_active}, 2'h0)
    for (int k = 0; k < 5; k++) begin
      xfer(mw(`SCAN_USER, 4'h0, 2'h0, 1'b0));
      `CHECK(channel, seq_list[19 - 4 * k -: 4])
    end
    complete_run();
  end
endmodule
